/* small_ram_32_deep_test.sv */
// Self-checking bench for the 32-word RAM cell
`timescale 1ns/1ns
`include "sr_ram_cfg.svh"
module small_ram_32_deep_test;
  localparam int W = 8;
  // Preset image of the 1-bit cell, any pattern will do
  localparam logic [31:0] IMAGE = 32'hA5C3_0F96;
  logic         ref_clk = 1'b0;
  logic         rst     = 1'b1;
  logic         write_clock;
  logic         write_enable;
  logic [4:0]   word_address;
  logic [W-1:0] data_in_bus;
  logic [W-1:0] data_out_bus;
  logic         data_out_bit;
  logic [W-1:0] data_out_lvl;
  logic [W-1:0] shadow [32];
  int           err_total = 0;
  int           checks    = 0;
  always #25 ref_clk = ~ref_clk;
  sr_user #(.DATA_W(W)) u_drv (
    .ref_clk(ref_clk), .write_clock(write_clock), .write_enable(write_enable),
    .word_address(word_address), .data_in_bus(data_in_bus));
  sr_ram32 #(.DATA_W(W)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .write_clock(write_clock), .write_enable(write_enable),
    .word_address(word_address), .data_in_bus(data_in_bus), .data_out_bus(data_out_bus));
  // Falling style with the clock flipped: it writes on the pin's rising edge
  sr_ram32 #(.DATA_W(1), .WRITE_MODE(sr_ram_pkg::SR_WRITE_FALL), .CLK_INVERT(1'b1),
    .INIT_IMAGE(IMAGE)) u_dut_bit (
    .ref_clk(ref_clk), .rst(rst), .write_clock(write_clock), .write_enable(write_enable),
    .word_address(word_address), .data_in_bus(data_in_bus[0]), .data_out_bus(data_out_bit));
  sr_ram32 #(.DATA_W(W), .WRITE_MODE(sr_ram_pkg::SR_WRITE_LEVEL)) u_dut_lvl (
    .ref_clk(ref_clk), .rst(rst), .write_clock(write_clock), .write_enable(write_enable),
    .word_address(word_address), .data_in_bus(data_in_bus), .data_out_bus(data_out_lvl));
  function automatic logic [W-1:0] expect_word(input logic [4:0] a);
    return shadow[a];
  endfunction : expect_word
  function automatic logic [W-1:0] expect_bit(input logic [4:0] a);
    return W'(shadow[a][0]);
  endfunction : expect_bit
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  // Run needs about 700 cycles
  initial
  begin
    #100000;
    err_total++;
    results();
  end
  initial
  begin
    logic [W-1:0] d;
    void'($urandom(32'h444d));
    repeat (4) @(posedge ref_clk);
    #5 rst = 1'b0;
    // Start values: preset image on the 1-bit cell, clear words elsewhere
    for (int a = 0; a < 32; a++)
    begin
      u_drv.look(5'(a));
      chk(data_out_bus, W'(`SR_WORD_RESET));
      chk(W'(data_out_bit), W'(IMAGE[a]));
      chk(data_out_lvl, W'(`SR_WORD_RESET));
    end
    // Every word, with all-ones and all-zeros at the ends
    for (int a = 0; a < 32; a++)
    begin
      d = (a == 31) ? 8'hFF : ((a == 0) ? 8'h00 : W'($urandom));
      u_drv.put(1'b1, 5'(a), d);
      shadow[a] = d;
      chk(data_out_bus, expect_word(5'(a)));
      chk(W'(data_out_bit), expect_bit(5'(a)));
      chk(data_out_lvl, expect_word(5'(a)));
    end
    // Clocked strobes with enable low must leave memory alone
    repeat (16) u_drv.put(1'b0, 5'($urandom), W'($urandom));
    for (int a = 31; a >= 0; a--)
    begin
      u_drv.look(5'(a));
      chk(data_out_bus, expect_word(5'(a)));
      chk(W'(data_out_bit), expect_bit(5'(a)));
      chk(data_out_lvl, expect_word(5'(a)));
    end
    results();
  end
endmodule : small_ram_32_deep_test

/* sr_ram32.sv */
// 32-word by 1/2/4/8-bit RAM cell with edge or level write and registered read
`timescale 1ns/1ns
`include "sr_ram_cfg.svh"

// Summary of operation
// - The memory holds 32 words picked by a 5-bit address, each 1, 2, 4 or 8 bits wide.
// - In the edge-written styles no write clock edge changes anything while enable is low.
// - In the rising style a low-to-high write clock edge with enable high stores the data.
// - In the falling 1-bit style only a high-to-low edge with enable high stores the bit.
// - The edge-written styles can flip the write clock polarity by a build option.
// - In the edge-written styles the output shows the word at the applied address.
// - In the level style the data is loaded into the addressed word while enable is high.
// - In the level style no stored word changes while enable is low, whatever address or data do.
// - In the level style the output always shows the addressed word.
// - Only the 1-bit cell takes a preset image; wider cells start from a fixed clear word.
module sr_ram32
  import sr_ram_pkg::*;
#(
  parameter int          DATA_W     = `SR_DEF_W,
  parameter sr_mode_type WRITE_MODE = SR_WRITE_RISE,
  parameter logic        CLK_INVERT = `SR_CLK_INVERT,
  parameter logic [`SR_DEPTH-1:0] INIT_IMAGE = `SR_INIT_IMAGE
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  write_clock,
  input  wire logic                  write_enable,
  input  wire logic [`SR_ADDR_W-1:0] word_address,
  input  wire logic [DATA_W-1:0]     data_in_bus,
  output logic      [DATA_W-1:0]     data_out_bus
);

  localparam int MAX_W = `SR_MAX_W;

  // ===========================================================
  // Pin synchronisers
  // All pins pass the same two stages so address, data and
  // enable stay aligned with the write clock they belong to.
  sr_req_type pin_req;
  sr_req_type meta_req;
  sr_req_type sync_req;
  logic       prev_clk;
  sr_req_type next_meta_req;
  sr_req_type next_sync_req;
  logic       next_prev_clk;
  logic       eff_clk;

  always_comb
  begin
    pin_req.wclk  = write_clock;
    pin_req.we    = write_enable;
    pin_req.addr  = word_address;
    pin_req.data  = MAX_W'(data_in_bus);
    next_meta_req = pin_req;
    next_sync_req = meta_req;
    // Polarity flip lives here, no gate on the pin itself
    eff_clk       = sync_req.wclk ^ CLK_INVERT;
    next_prev_clk = eff_clk;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_req <= `SR_REQ_RESET;
      sync_req <= `SR_REQ_RESET;
      // Idle level of the tracker matches the adjusted clock: no false edge
      prev_clk <= CLK_INVERT;
    end
    else
    begin
      meta_req <= next_meta_req;
      sync_req <= next_sync_req;
      prev_clk <= next_prev_clk;
    end
  end

  // ===========================================================
  // Write decision
  logic rise_seen;
  logic fall_seen;
  logic do_write;

  always_comb
  begin
    rise_seen = eff_clk & ~prev_clk;
    fall_seen = ~eff_clk & prev_clk;
    do_write  = 1'b0;
    unique case (WRITE_MODE)
      SR_WRITE_RISE:  do_write = sync_req.we & rise_seen;
      SR_WRITE_FALL:  do_write = sync_req.we & fall_seen;
      SR_WRITE_LEVEL: do_write = sync_req.we;
    endcase
  end

  // ===========================================================
  // Word decode
  // One compare per word; used by the strobes only, the checks compare the address directly
  function automatic logic word_hit
  (
    input logic [`SR_ADDR_W-1:0] addr,
    input int                    idx
  );
    return addr == `SR_ADDR_W'(idx);
  endfunction : word_hit

  logic [`SR_DEPTH-1:0] word_sel;

  generate
    for (genvar g = 0; g < `SR_DEPTH; g++)
    begin : g_word_sel
      assign word_sel[g] = do_write & word_hit(sync_req.addr, g);
    end
  endgenerate

  // ===========================================================
  // Storage and read path
  logic [DATA_W-1:0] mem      [`SR_DEPTH];
  logic [DATA_W-1:0] next_mem [`SR_DEPTH];
  logic [DATA_W-1:0] next_data_out;

  // Read is registered: three cycles behind the pins, but the
  // output comes straight from a flip-flop on the one clock
  always_comb
  begin
    for (int i = 0; i < `SR_DEPTH; i++)
    begin
      if (word_sel[i])
      begin
        next_mem[i] = sync_req.data[DATA_W-1:0];
      end
      else
      begin
        next_mem[i] = mem[i];
      end
    end
    // Read from the next image so a fresh write shows at once
    next_data_out = next_mem[sync_req.addr];
  end

  // Reset stands in for configuration: the 1-bit cell loads its
  // preset image, wider cells start from a fixed clear word so the
  // read path never shows unknowns; they take no user image.
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < `SR_DEPTH; i++)
    begin
      if (rst)
      begin
        mem[i] <= (DATA_W == 1) ? DATA_W'(INIT_IMAGE[i]) : DATA_W'(`SR_WORD_RESET);
      end
      else
      begin
        mem[i] <= next_mem[i];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      data_out_bus <= DATA_W'(`SR_OUT_RESET);
    end
    else
    begin
      data_out_bus <= next_data_out;
    end
  end

  // ===========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_width_legal: assert property (
    (DATA_W == 1 || DATA_W == 2 || DATA_W == 4 || DATA_W == 8)
    && (WRITE_MODE != SR_WRITE_FALL || DATA_W == 1))
    else $error("illegal width or style");

  a_idle_no_write: assert property (
    !sync_req.we |-> !do_write)
    else $error("write with enable low");

  a_rise_edge_only: assert property (
    (WRITE_MODE == SR_WRITE_RISE && do_write) |-> (eff_clk && !$past(eff_clk)))
    else $error("rising style wrote off a rising edge");

  a_fall_edge_only: assert property (
    (WRITE_MODE == SR_WRITE_FALL && do_write) |-> (!eff_clk && $past(eff_clk)))
    else $error("falling style wrote off a falling edge");

  a_level_loads: assert property (
    (WRITE_MODE == SR_WRITE_LEVEL && sync_req.we) |-> do_write)
    else $error("level style missed a load");

  a_write_reads_back: assert property (
    do_write |=> data_out_bus == $past(sync_req.data[DATA_W-1:0]))
    else $error("new word not shown after write");

  a_read_follows: assert property (
    !do_write |=> data_out_bus == $past(mem[sync_req.addr]))
    else $error("output is not the addressed word");

  a_hold_contents: assert property (
    (!do_write && $stable(sync_req.addr)) ##1 (!do_write && $stable(sync_req.addr))
    |-> $stable(data_out_bus))
    else $error("contents moved without a write");

  // ===========================================================
  // Reset, pipeline and write decision checks
  // Level pulses shorter than one ref_clk period may be missed.
  a_out_cleared: assert property (
    $fell(rst) |-> data_out_bus == DATA_W'(`SR_OUT_RESET))
    else $error("output not cleared by reset");

  a_meta_follows: assert property (
    !$past(rst) |-> meta_req == $past(pin_req))
    else $error("first stage lost a pin value");

  a_pipe_aligned: assert property (
    sync_req == $past(meta_req))
    else $error("second stage out of step");

  a_edge_tracker: assert property (
    prev_clk == $past(eff_clk))
    else $error("edge tracker out of step");

  a_write_needs_we: assert property (
    do_write |-> sync_req.we)
    else $error("write without enable");

  a_clock_ignored: assert property (
    (!sync_req.we && (rise_seen || fall_seen)) |-> !do_write)
    else $error("clock edge wrote with enable low");

  a_level_quiet: assert property (
    (WRITE_MODE == SR_WRITE_LEVEL && !sync_req.we) |-> !do_write)
    else $error("level style wrote with enable low");

  a_level_reads: assert property (
    (WRITE_MODE == SR_WRITE_LEVEL && do_write) |=> data_out_bus == $past(sync_req.data[DATA_W-1:0]))
    else $error("level style hid the loaded word");

  a_rise_ignored: assert property (
    (WRITE_MODE == SR_WRITE_FALL && rise_seen) |-> !do_write)
    else $error("falling style wrote on a rising edge");

  a_fall_ignored: assert property (
    (WRITE_MODE == SR_WRITE_RISE && fall_seen) |-> !do_write)
    else $error("rising style wrote on a falling edge");

  a_rise_writes: assert property (
    (WRITE_MODE == SR_WRITE_RISE && sync_req.we && rise_seen) |-> do_write)
    else $error("rising style missed a write");

  a_fall_writes: assert property (
    (WRITE_MODE == SR_WRITE_FALL && sync_req.we && fall_seen) |-> do_write)
    else $error("falling style missed a write");

  // ===========================================================
  // Storage checks
  a_one_word: assert property (
    $onehot0(word_sel))
    else $error("more than one word strobed");

  a_strobe_match: assert property (
    do_write |-> $onehot(word_sel))
    else $error("write without a word strobe");

  generate
    for (genvar k = 0; k < `SR_DEPTH; k++)
    begin : g_word_chk
      a_word_target: assert property (
        word_sel[k] |-> sync_req.addr == `SR_ADDR_W'(k))
        else $error("strobe on the wrong word");

      a_word_lands: assert property (
        word_sel[k] |=> mem[k] == $past(sync_req.data[DATA_W-1:0]))
        else $error("strobed word did not take the data");

      a_word_holds: assert property (
        !word_sel[k] |=> $stable(mem[k]))
        else $error("unstrobed word changed");

      a_word_read: assert property (
        (!do_write && sync_req.addr == `SR_ADDR_W'(k)) |=> data_out_bus == $past(mem[k]))
        else $error("output is not the stored word");

      a_word_preset: assert property (
        $fell(rst)
        |-> mem[k] == ((DATA_W == 1) ? DATA_W'(INIT_IMAGE[k]) : DATA_W'(`SR_WORD_RESET)))
        else $error("word start value wrong");
    end
  endgenerate

endmodule : sr_ram32

/* sr_ram_cfg.svh */
// Constants for the 32-word distributed RAM cell
`ifndef SR_RAM_CFG_SVH
`define SR_RAM_CFG_SVH

// =============================================================
// Geometry
`define SR_ADDR_W      5
`define SR_DEPTH       32
`define SR_MAX_W       8
`define SR_DEF_W       1

// =============================================================
// Reset and configuration defaults
`define SR_INIT_IMAGE  32'h00000000
`define SR_WORD_RESET  8'h00
`define SR_OUT_RESET   8'h00
`define SR_REQ_RESET   15'h0000
`define SR_CLK_INVERT  1'b0

`endif

/* sr_ram_pkg.sv */
// Types shared by the 32-word distributed RAM cell
`include "sr_ram_cfg.svh"

package sr_ram_pkg;

  // ===========================================================
  // Write style of the cell, one-hot
  typedef enum logic [2:0] {
    SR_WRITE_RISE  = 3'b001,
    SR_WRITE_FALL  = 3'b010,
    SR_WRITE_LEVEL = 3'b100
  } sr_mode_type;

  // ===========================================================
  // Pin group as seen after synchronisation
  typedef struct packed {
    logic                   wclk;
    logic                   we;
    logic [`SR_ADDR_W-1:0]  addr;
    logic [`SR_MAX_W-1:0]   data;
  } sr_req_type;

endpackage : sr_ram_pkg

/* sr_user.sv */
// User logic model that drives the RAM cell pins
`timescale 1ns/1ns
`include "sr_ram_cfg.svh"
module sr_user
  import sr_ram_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input  wire logic              ref_clk,
  output logic                   write_clock,
  output logic                   write_enable,
  output logic [`SR_ADDR_W-1:0]  word_address,
  output logic [DATA_W-1:0]      data_in_bus
);
  initial
  begin
    {write_clock, write_enable, word_address, data_in_bus} = '0;
  end
  // Pins held two cycles around the active edge
  task automatic put(input logic we, input logic [`SR_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    #5 {write_clock, write_enable, word_address, data_in_bus} = {1'b0, we, a, d};
    repeat (2) @(posedge ref_clk);
    #5 write_clock = 1'b1;
    repeat (2) @(posedge ref_clk);
    #5 write_clock = 1'b0;
    repeat (2) @(posedge ref_clk);
    // Released data is inverted, never left looking valid
    #5 {write_enable, data_in_bus} = {1'b0, ~d};
  endtask : put
  task automatic look(input logic [`SR_ADDR_W-1:0] a);
    @(posedge ref_clk);
    #5 word_address = a;
    repeat (4) @(posedge ref_clk);
    #5;
  endtask : look
endmodule : sr_user
